// ### hdl/rssc_consts.svh
// Register map, field positions, reset values and delay timing for the
// rail strobe sequencer. Included by the slot decoder and the sequencer module.
`ifndef RSSC_CONSTS_SVH
`define RSSC_CONSTS_SVH

// Register indices; the byte address on APB is four times the index
`define RSSC_IDX_DELAY_SEL 8'h20
`define RSSC_IDX_FACTOR 8'h21
`define RSSC_IDX_BUCK12 8'h22
`define RSSC_IDX_BUCK34 8'h23
`define RSSC_IDX_STATUS 8'h30

// Reset values
`define RSSC_RST_DELAY_SEL 8'h00
`define RSSC_RST_FACTOR 8'h00
`define RSSC_RST_BUCK12 8'h98
`define RSSC_RST_BUCK34 8'h75

// Field positions
`define RSSC_FACTOR_BIT 7
`define RSSC_SLOT9_BIT 0
`define RSSC_HI_CODE_MSB 7
`define RSSC_HI_CODE_LSB 4
`define RSSC_LO_CODE_MSB 3
`define RSSC_LO_CODE_LSB 0

// Strobe numbering and valid slot codes
`define RSSC_FIRST_STROBE 4'h1
`define RSSC_LAST_STROBE 4'hA
`define RSSC_FIRST_CODE 4'h3
`define RSSC_LAST_CODE 4'hA

// Timing: delays in microseconds, clock in MHz
`define RSSC_SHORT_DELAY_US 2000
`define RSSC_LONG_DELAY_US 5000
`define RSSC_CLK_MHZ 50
`define RSSC_SHORT_DELAY_CYC (`RSSC_SHORT_DELAY_US * `RSSC_CLK_MHZ)
`define RSSC_LONG_DELAY_CYC (`RSSC_LONG_DELAY_US * `RSSC_CLK_MHZ)
`define RSSC_PD_FACTOR 10

`endif

// ### hdl/rssc_pkg.sv
// Types shared by the rail strobe sequencer.
// Constants live in rssc_consts.svh.
package rssc_pkg;

	typedef enum logic [1:0] {
		RSSC_IDLE = 2'b00,
		RSSC_WAIT = 2'b01,
		RSSC_FIRE = 2'b10
	} rssc_state_t;

	typedef struct packed {
		logic [7:0] delay_sel;
		logic powerdown_delay_multiplier;
		logic slot9_delay_sel;
		logic [3:0] buck2_slot_code;
		logic [3:0] buck1_slot_code;
		logic [3:0] buck4_slot_code;
		logic [3:0] buck3_slot_code;
	} rssc_regs_t;

	typedef struct packed {
		logic busy;
		logic powering_down;
		logic [3:0] strobe;
		logic [3:0] rail_en;
	} rssc_status_t;

endpackage : rssc_pkg

// ### hdl/rssc_delay_timer.sv
// Down counter for one inter-strobe delay.
// Assumes load is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/1ps
module rssc_delay_timer #(
	parameter int CNT_W = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [CNT_W-1:0] count,
	output logic done
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic done_nxt;

	initial begin
		if (CNT_W < 2)
			$error("rssc_delay_timer: CNT_W too small");
	end

	// Done rises count-1 edges after the load edge, so the strobe that
	// follows lands count+1 cycles after the one that loaded; count >= 2
	assign done_nxt = !load && (cnt_r == CNT_W'(2));
	assign cnt_nxt = load ? count :
		(cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done <= done_nxt;
		end
	end
endmodule : rssc_delay_timer

// ### hdl/rssc_slot_decode.sv
// Decodes one rail's slot code against the strobe now firing.
// Purely combinational; the sequencer registers the result.
`timescale 1ns/1ps
`include "rssc_consts.svh"
module rssc_slot_decode (
	input wire logic [3:0] code,
	input wire logic [3:0] strobe,
	output logic hit
);
	function automatic logic code_valid(input logic [3:0] c);
		code_valid = (c >= `RSSC_FIRST_CODE) && (c <= `RSSC_LAST_CODE);
	endfunction : code_valid

	// Codes outside 3..A leave the rail out of sequencing
	assign hit = code_valid(code) && (code == strobe);
endmodule : rssc_slot_decode

// ### hdl/rssc_seq.sv
// Rail strobe sequencer: APB registers for delays and slot codes, plus
// the strobe engine that walks strobes 1..10 up and 10..1 down.
// Assumes power_up_req and power_down_req come from pins (synchronised
// here) and that the APB master obeys the usual setup/access phases.
//
// Contract
// - Delay slot k is 2 ms or 5 ms
// - Slots 8..1 select at bits 7..0
// - Slot 9 select at bit 0 of second
// - Multiplier bit 7 scales power-down delays tenfold
// - Power-up delays never scaled
// - Codes 3..A enable rail at that strobe
// - Other codes leave rail unsequenced
// - Second rail code bits 7-4, reset 9
// - First rail code bits 3-0, reset 8
// - Delay-select register resets to zero
// - Third/fourth rail register resets to 0x75
// - Fourth rail high nibble, third low nibble
`timescale 1ns/1ps
`include "rssc_consts.svh"
module rssc_seq #(
	parameter int ADDR_W = 12,
	parameter int CNT_W = 24,
	parameter int SHORT_CYC = `RSSC_SHORT_DELAY_CYC,
	parameter int LONG_CYC = `RSSC_LONG_DELAY_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_up_req,
	input wire logic power_down_req,
	output logic [3:0] rail_en,
	output logic strobe_pulse,
	output logic seq_busy
);
	initial begin
		if (ADDR_W < 10)
			$error("rssc_seq: ADDR_W cannot reach the map");
		// The timer needs a count of at least two to raise done
		if (SHORT_CYC < 2 || LONG_CYC < SHORT_CYC)
			$error("rssc_seq: bad delay counts");
		if (longint'(LONG_CYC) * `RSSC_PD_FACTOR >= (longint'(1) << CNT_W))
			$error("rssc_seq: CNT_W too small for scaled delay");
	end

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = ADDR_W'({idx, 2'b00});
	endfunction : byte_addr

	// ---------------- APB register file ----------------
	rssc_pkg::rssc_regs_t regs_r;
	rssc_pkg::rssc_regs_t regs_nxt;
	rssc_pkg::rssc_status_t status;
	logic [31:0] rdata_nxt;
	logic err_nxt;

	wire setup_ph = psel && !penable;
	wire wr_take = psel && penable && pready && pwrite;
	wire sel_dly = paddr == byte_addr(`RSSC_IDX_DELAY_SEL);
	wire sel_fct = paddr == byte_addr(`RSSC_IDX_FACTOR);
	wire sel_b12 = paddr == byte_addr(`RSSC_IDX_BUCK12);
	wire sel_b34 = paddr == byte_addr(`RSSC_IDX_BUCK34);
	wire sel_sts = paddr == byte_addr(`RSSC_IDX_STATUS);
	wire mapped = sel_dly || sel_fct || sel_b12 || sel_b34 || sel_sts;
	// Status is read-only; a write to it is refused like an unmapped one
	wire bad_acc = !mapped || (sel_sts && pwrite);

	wire [7:0] fct_byte = {regs_r.powerdown_delay_multiplier, 6'h00,
		regs_r.slot9_delay_sel};
	wire [7:0] b12_byte = {regs_r.buck2_slot_code, regs_r.buck1_slot_code};
	wire [7:0] b34_byte = {regs_r.buck4_slot_code, regs_r.buck3_slot_code};

	assign rdata_nxt = (!setup_ph || pwrite) ? 32'h0000_0000 :
		sel_dly ? {24'h00_0000, regs_r.delay_sel} :
		sel_fct ? {24'h00_0000, fct_byte} :
		sel_b12 ? {24'h00_0000, b12_byte} :
		sel_b34 ? {24'h00_0000, b34_byte} :
		sel_sts ? {22'h0, status} : 32'h0000_0000;
	assign err_nxt = setup_ph && bad_acc;

	always_comb begin
		regs_nxt = regs_r;
		if (wr_take && !pslverr) begin
			if (sel_dly)
				regs_nxt.delay_sel = pwdata[7:0];
			if (sel_fct) begin
				regs_nxt.powerdown_delay_multiplier = pwdata[`RSSC_FACTOR_BIT];
				regs_nxt.slot9_delay_sel = pwdata[`RSSC_SLOT9_BIT];
			end
			if (sel_b12) begin
				regs_nxt.buck2_slot_code =
					pwdata[`RSSC_HI_CODE_MSB:`RSSC_HI_CODE_LSB];
				regs_nxt.buck1_slot_code =
					pwdata[`RSSC_LO_CODE_MSB:`RSSC_LO_CODE_LSB];
			end
			if (sel_b34) begin
				regs_nxt.buck4_slot_code =
					pwdata[`RSSC_HI_CODE_MSB:`RSSC_HI_CODE_LSB];
				regs_nxt.buck3_slot_code =
					pwdata[`RSSC_LO_CODE_MSB:`RSSC_LO_CODE_LSB];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs_r.delay_sel <= `RSSC_RST_DELAY_SEL;
			regs_r.powerdown_delay_multiplier <= 1'b0;
			regs_r.slot9_delay_sel <= 1'b0;
			regs_r.buck2_slot_code <= 4'(`RSSC_RST_BUCK12 >> 4);
			regs_r.buck1_slot_code <= 4'(`RSSC_RST_BUCK12);
			regs_r.buck4_slot_code <= 4'(`RSSC_RST_BUCK34 >> 4);
			regs_r.buck3_slot_code <= 4'(`RSSC_RST_BUCK34);
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			regs_r <= regs_nxt;
			prdata <= rdata_nxt;
			pready <= setup_ph;
			pslverr <= err_nxt;
		end
	end

	// ---------------- Request synchronisers ----------------
	logic [2:0] up_sync_r;
	logic [2:0] dn_sync_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_sync_r <= 3'h0;
			dn_sync_r <= 3'h0;
		end else begin
			up_sync_r <= {up_sync_r[1:0], power_up_req};
			dn_sync_r <= {dn_sync_r[1:0], power_down_req};
		end
	end
	// Edges only look at the second and third stages
	wire up_edge = up_sync_r[1] && !up_sync_r[2];
	wire dn_edge = dn_sync_r[1] && !dn_sync_r[2];

	// ---------------- Strobe engine ----------------
	rssc_pkg::rssc_state_t state_r;
	rssc_pkg::rssc_state_t state_nxt;
	logic [3:0] strobe_r;
	logic [3:0] strobe_nxt;
	logic down_r;
	logic down_nxt;
	logic [3:0] hit;
	logic [3:0] rail_nxt;
	logic tmr_load;
	logic tmr_done;
	logic [CNT_W-1:0] tmr_count;
	logic [3:0] slot;

	logic [3:0] codes [4];
	assign codes = '{regs_r.buck1_slot_code, regs_r.buck2_slot_code,
		regs_r.buck3_slot_code, regs_r.buck4_slot_code};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_rail
			rssc_slot_decode u_dec (
				.code(codes[g]),
				.strobe(strobe_r),
				.hit(hit[g])
			);
		end
	endgenerate

	// Slot select: slots 1..8 from the first register, 9 from the second
	function automatic logic slot_long(input rssc_pkg::rssc_regs_t r,
		input logic [3:0] k);
		if (k == 4'h9)
			slot_long = r.slot9_delay_sel;
		else
			slot_long = r.delay_sel[3'(k - 4'h1)];
	endfunction : slot_long

	// Going down, the gap before strobe k-1 is slot k-1
	assign slot = down_r ? strobe_r - 4'h1 : strobe_r;
	wire [CNT_W-1:0] base_cyc = slot_long(regs_r, slot) ?
		CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);
	// Scaling is applied only on the power-down walk
	wire scale = down_r && regs_r.powerdown_delay_multiplier;
	assign tmr_count = scale ?
		CNT_W'(base_cyc * CNT_W'(`RSSC_PD_FACTOR)) : base_cyc;
	wire last = down_r ? (strobe_r == `RSSC_FIRST_STROBE) :
		(strobe_r == `RSSC_LAST_STROBE);

	assign tmr_load = (state_r == rssc_pkg::RSSC_FIRE) && !last;

	rssc_delay_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	always_comb begin
		state_nxt = state_r;
		strobe_nxt = strobe_r;
		down_nxt = down_r;
		case (state_r)
			rssc_pkg::RSSC_IDLE: begin
				// A power-down request wins if both arrive together
				if (dn_edge) begin
					down_nxt = 1'b1;
					strobe_nxt = `RSSC_LAST_STROBE;
					state_nxt = rssc_pkg::RSSC_FIRE;
				end else if (up_edge) begin
					down_nxt = 1'b0;
					strobe_nxt = `RSSC_FIRST_STROBE;
					state_nxt = rssc_pkg::RSSC_FIRE;
				end
			end
			rssc_pkg::RSSC_FIRE: begin
				state_nxt = last ? rssc_pkg::RSSC_IDLE :
					rssc_pkg::RSSC_WAIT;
			end
			rssc_pkg::RSSC_WAIT: begin
				if (tmr_done) begin
					strobe_nxt = down_r ? strobe_r - 4'h1 :
						strobe_r + 4'h1;
					state_nxt = rssc_pkg::RSSC_FIRE;
				end
			end
			default: begin
				state_nxt = rssc_pkg::RSSC_IDLE;
			end
		endcase
	end

	// Rails outside sequencer control keep their level
	wire firing = state_r == rssc_pkg::RSSC_FIRE;
	assign rail_nxt = !firing ? rail_en :
		down_r ? (rail_en & ~hit) : (rail_en | hit);

	assign status = '{busy: seq_busy, powering_down: down_r,
		strobe: strobe_r, rail_en: rail_en};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= rssc_pkg::RSSC_IDLE;
			strobe_r <= 4'h0;
			down_r <= 1'b0;
			rail_en <= 4'h0;
			strobe_pulse <= 1'b0;
			seq_busy <= 1'b0;
		end else begin
			state_r <= state_nxt;
			strobe_r <= strobe_nxt;
			down_r <= down_nxt;
			rail_en <= rail_nxt;
			strobe_pulse <= state_nxt == rssc_pkg::RSSC_FIRE;
			seq_busy <= state_nxt != rssc_pkg::RSSC_IDLE;
		end
	end

	// ---------------- Assertions ----------------
	logic dly_written_r;
	logic b12_written_r;
	logic b34_written_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_written_r <= 1'b0;
			b12_written_r <= 1'b0;
			b34_written_r <= 1'b0;
		end else begin
			dly_written_r <= dly_written_r || (wr_take && sel_dly);
			b12_written_r <= b12_written_r || (wr_take && sel_b12);
			b34_written_r <= b34_written_r || (wr_take && sel_b34);
		end
	end

	a_slot_length: assert property (@(posedge pclk) disable iff (!presetn)
		tmr_load && !down_r |-> tmr_count ==
			(slot_long(regs_r, strobe_r) ? CNT_W'(LONG_CYC) :
			CNT_W'(SHORT_CYC)))
		else $error("power-up delay slot length wrong");
	a_delay_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && sel_dly && !pslverr |=> regs_r.delay_sel ==
			$past(pwdata[7:0]))
		else $error("delay select write not stored");
	a_slot9_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && sel_fct |=> regs_r.slot9_delay_sel == $past(pwdata[0]))
		else $error("slot 9 select not stored at bit 0");
	a_down_scaled: assert property (@(posedge pclk) disable iff (!presetn)
		tmr_load && down_r && regs_r.powerdown_delay_multiplier |->
			tmr_count == CNT_W'(base_cyc * CNT_W'(`RSSC_PD_FACTOR)))
		else $error("power-down delay not scaled tenfold");
	a_up_unscaled: assert property (@(posedge pclk) disable iff (!presetn)
		tmr_load && !down_r |-> tmr_count <= CNT_W'(LONG_CYC))
		else $error("power-up delay was scaled");
	a_rail_on: assert property (@(posedge pclk) disable iff (!presetn)
		firing && !down_r && codes[0] == strobe_r &&
			codes[0] >= `RSSC_FIRST_CODE &&
			codes[0] <= `RSSC_LAST_CODE |=> rail_en[0])
		else $error("rail not enabled at its strobe");
	a_rail_free: assert property (@(posedge pclk) disable iff (!presetn)
		firing && (codes[1] < `RSSC_FIRST_CODE ||
			codes[1] > `RSSC_LAST_CODE) |=> $stable(rail_en[1]))
		else $error("unsequenced rail changed");
	a_b12_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!b12_written_r |-> b12_byte == `RSSC_RST_BUCK12)
		else $error("first pair slot codes lost reset value");
	a_dly_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!dly_written_r |-> regs_r.delay_sel == `RSSC_RST_DELAY_SEL)
		else $error("delay select lost reset value");
	a_b34_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!b34_written_r |-> b34_byte == `RSSC_RST_BUCK34)
		else $error("second pair slot codes lost reset value");
	a_strobe_step: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == rssc_pkg::RSSC_WAIT && tmr_done && !down_r |=>
			firing && strobe_r == $past(strobe_r) + 4'h1)
		else $error("power-up strobe did not advance by one");

	c_up_done: cover property (@(posedge pclk) disable iff (!presetn)
		firing && !down_r && strobe_r == `RSSC_LAST_STROBE);
	c_down_done: cover property (@(posedge pclk) disable iff (!presetn)
		firing && down_r && strobe_r == `RSSC_FIRST_STROBE);
	c_scaled: cover property (@(posedge pclk) disable iff (!presetn)
		tmr_load && scale);
	c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pslverr);
endmodule : rssc_seq

// ### tb/rssc_apb_host.sv
// APB host model that configures the sequencer registers.
// Assumes one clock shared with the slave and one transfer at a time.
`timescale 1ns/1ps
module rssc_apb_host (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// Released address and data lines show inverted values so stale data cannot pass
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : rssc_apb_host

// ### tb/test_rail_strobe_sequencer_config.sv
// Self-checking bench for the rail strobe sequencer.
// Assumes shortened delays: 10 cycles short, 25 cycles long.
`timescale 1ns/1ps
module test_rail_strobe_sequencer_config;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, d;
	logic power_up_req = 1'b0;
	logic power_down_req = 1'b0;
	logic [3:0] rail_en, rail_exp;
	logic strobe_pulse, seq_busy, s9, fac, rail_due;
	logic [3:0] codes [4];
	logic [7:0] dsel;
	logic [33:0] apb_q [$];
	logic [33:0] e;
	int gap_q [$];
	logic [3:0] rail_q [$];
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int last_cyc = 0;
	int g;

	always #10 pclk = ~pclk;

	rssc_seq #(.SHORT_CYC(10), .LONG_CYC(25)) rssc_seq_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .power_up_req(power_up_req),
		.power_down_req(power_down_req), .rail_en(rail_en),
		.strobe_pulse(strobe_pulse), .seq_busy(seq_busy));

	rssc_apb_host rssc_apb_host_inst (.pclk(pclk), .pready(pready),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic int dly(input int k);
		logic b;
		b = (k == 9) ? s9 : dsel[k-1];
		return b ? 25 : 10;
	endfunction : dly

	task automatic cmp(input string n, input logic [31:0] x,
		input logic [31:0] y);
		checked++;
		if (x !== y) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, x, y);
		end
	endtask : cmp

	task automatic finish_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] dat, input logic [31:0] x, input logic err);
		apb_q.push_back({w, err, x});
		rssc_apb_host_inst.xfer(w, a, dat);
	endtask : acc

	// Down walk fires 10..1; the gap before strobe s uses slot s
	task automatic walk(input logic up);
		int s;
		logic [3:0] r;
		for (int n = 1; n <= 10; n++) begin
			s = up ? n : 11 - n;
			if (n == 1)
				gap_q.push_back(0);
			else
				gap_q.push_back(dly(up ? s - 1 : s) * ((!up && fac) ? 10 : 1) + 1);
			for (int i = 0; i < 4; i++)
				r[i] = codes[i] >= 4'h3 && codes[i] <= 4'hA &&
					(up ? codes[i] <= s : codes[i] < s);
			rail_q.push_back(r);
		end
		@(posedge pclk);
		if (up)
			power_up_req <= 1'b1;
		else
			power_down_req <= 1'b1;
		repeat (10) @(posedge pclk);
		while (seq_busy !== 1'b0) @(posedge pclk);
		power_up_req <= 1'b0;
		power_down_req <= 1'b0;
		repeat (4) @(posedge pclk);
		cmp("strobes left", 0, gap_q.size());
		// Status after the walk: idle, direction, last strobe, rail levels
		acc(0, 12'h0C0, 0, {22'h0, 1'b0, !up, up ? 4'hA : 4'h1, r}, 0);
	endtask : walk

	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			finish_test();
		end
	end

	always @(posedge pclk) begin
		if (rail_due)
			cmp("rail_en", rail_exp, rail_en);
		rail_due = 1'b0;
		if (psel && penable && pready === 1'b1) begin
			e = apb_q.pop_front();
			cmp("pslverr", e[32], pslverr);
			if (!e[33])
				cmp("prdata", e[31:0], prdata);
		end
		if (strobe_pulse === 1'b1) begin
			cmp("extra strobe", 1, gap_q.size() != 0);
			cmp("seq_busy", 1, seq_busy);
			g = gap_q.pop_front();
			if (g != 0)
				cmp("gap", g, cyc - last_cyc);
			last_cyc = cyc;
			rail_exp = rail_q.pop_front();
			rail_due = 1'b1;
		end
	end

	initial begin
		seed = 32'h0000005F;
		rail_due = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		acc(0, 12'h080, 0, 32'h00, 0);
		acc(0, 12'h084, 0, 32'h00, 0);
		acc(0, 12'h088, 0, 32'h98, 0);
		acc(0, 12'h08C, 0, 32'h75, 0);
		$display("test reset values done");
		d = rnd();
		acc(1, 12'h080, d, 0, 0);
		acc(0, 12'h080, 0, {24'h0, d[7:0]}, 0);
		acc(1, 12'h084, 32'hFFFFFFFF, 0, 0);
		acc(0, 12'h084, 0, 32'h81, 0);
		acc(1, 12'h08C, d, 0, 0);
		acc(0, 12'h08C, 0, {24'h0, d[7:0]}, 0);
		acc(0, 12'h0FC, 0, 32'h00, 1);
		acc(1, 12'h0C0, d, 0, 1);
		$display("test access kinds done");
		for (int r = 0; r < 4; r++) begin
			d = rnd();
			dsel = d[7:0];
			s9 = d[8];
			fac = r[0];
			for (int i = 0; i < 4; i++)
				codes[i] = 4 * r + i;
			acc(1, 12'h080, {24'h0, dsel}, 0, 0);
			acc(1, 12'h084, {24'h0, fac, 6'h00, s9}, 0, 0);
			acc(1, 12'h088, {24'h0, codes[1], codes[0]}, 0, 0);
			acc(1, 12'h08C, {24'h0, codes[3], codes[2]}, 0, 0);
			walk(1'b1);
			walk(1'b0);
			$display("test walk round %0d done", r);
		end
		finish_test();
	end
endmodule : test_rail_strobe_sequencer_config
